// >>> include/fkr_pkg.sv
// Purpose: shared constants and types of the fsk receive filter and slicer
// Assumes: hclk stands in for the crystal clock
// Notes: register offsets are byte addresses on the ahb-lite slave
package fkr_pkg;
    localparam logic [7:0] OFF_CFG_A  = 8'h00;
    localparam logic [7:0] OFF_FCTL   = 8'h04;
    localparam logic [7:0] OFF_CLOCK  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_OFFSET = 8'h10;
    localparam logic [7:0] OFF_DATA   = 8'h14;
    // field positions
    localparam int POS_ADC_DIV  = 0;
    localparam int POS_DECIMATION_DIVIDER  = 4;
    localparam int POS_BYPASS   = 12;
    localparam int POS_DEV_M    = 0;
    localparam int POS_DEV_X    = 4;
    localparam int POS_SETTLE   = 8;
    localparam int POS_REF_DIV  = 0;
    localparam int POS_DIV1     = 4;
    localparam int POS_DIV2     = 8;
    localparam int POS_OVERRUN  = 8;
    localparam int POS_LOCKED   = 9;
    // reset values
    localparam logic [2:0] RST_ADC_DIV = 3'h3;
    localparam logic [4:0] RST_DECIMATION_DIVIDER = 5'h00;
    localparam logic [3:0] RST_DEV_M   = 4'h4;
    localparam logic [1:0] RST_DEV_X   = 2'h1;
    localparam logic [1:0] RST_SETTLE  = 2'h2;
    localparam logic [2:0] RST_REF_DIV = 3'h0;
    localparam logic [2:0] RST_DIV1    = 3'h0;
    localparam logic [1:0] RST_DIV2    = 2'h0;
    // rate constants
    localparam int IF_PER_ADC    = 4;
    localparam int ADC_BASE_DIV  = 2;
    localparam int OVERSAMPLE    = 4;
    localparam int MIN_TRANS     = 3;
    localparam int FIFO_DEPTH    = 16;
    localparam int FIFO_WIDTH    = 8;

    typedef struct packed {
        logic       bypass;
        logic [4:0] decimation_divider;
        logic [2:0] adc_div;
    } fkr_cfg_a_t;

    typedef struct packed {
        logic [1:0] slicer_average_length;
        logic [1:0] expected_dev_exponent;
        logic [3:0] expected_dev_mantissa;
    } fkr_fctl_t;

    typedef struct packed {
        logic [1:0] master_clock_div_second;
        logic [2:0] master_clock_div_first;
        logic [2:0] ref_div;
    } fkr_clock_t;
endpackage : fkr_pkg

// >>> design/fkr_fifo.sv
// Purpose: byte buffer between the bit synchronizer and the register bus
// Assumes: single clock, flip-flop storage
// Notes: in_ready drops when full, out_valid drops when empty
`timescale 1ns/1ps
`default_nettype none
module fkr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + AW'(1);
            if (pop) rd_q <= rd_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    property p_no_overflow;
        @(posedge hclk) disable iff (!hresetn)
        cnt_q <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count beyond depth");
endmodule : fkr_fifo
`default_nettype wire

// >>> design/fkr_rx_core.sv
// Purpose: IF clocking, channel decimation, adaptive slicer and bit synchronizer
// Assumes: demod_freq is the instantaneous frequency relative to the IF
// Notes: received bits pack lsb first into bytes read from the data register
`timescale 1ns/1ps
`default_nettype none
module fkr_rx_core
    import fkr_pkg::*;
(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // demodulated sample stream
    input  wire logic signed [7:0] demod_freq,
    input  wire logic              demod_valid,
    output logic                   demod_ready,
    // radio side controls and data
    output logic                   adc_clk_en,
    output logic                   if_clk_en,
    output logic                   filter_bypass,
    output logic                   sliced_bit,
    output logic                   rx_bit,
    output logic                   rx_bit_valid
);
    fkr_cfg_a_t cfg_q;
    fkr_fctl_t  fctl_q;
    fkr_clock_t clk_q;

    // bus slave: writes land in the data phase, reads are sampled at the address phase
    logic        addr_ph;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rmux;
    logic        pop;
    logic        overrun_q;
    logic        overrun_set;
    logic        locked;
    logic signed [7:0] level_q;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic [4:0]  fifo_count;

    assign addr_ph   = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign pop       = addr_ph & ~hwrite & (haddr[7:0] == OFF_DATA);

    always_comb begin
        rmux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_CFG_A:  rmux = {19'h0, cfg_q.bypass, 3'h0, cfg_q.decimation_divider, 1'b0, cfg_q.adc_div};
            OFF_FCTL:   rmux = {22'h0, fctl_q.slicer_average_length, 2'h0,
                                fctl_q.expected_dev_exponent, fctl_q.expected_dev_mantissa};
            OFF_CLOCK:  rmux = {22'h0, clk_q.master_clock_div_second, 1'b0,
                                clk_q.master_clock_div_first, 1'b0, clk_q.ref_div};
            OFF_STATUS: rmux = {22'h0, locked, overrun_q, 3'h0, fifo_count};
            OFF_OFFSET: rmux = {{24{level_q[7]}}, level_q};
            OFF_DATA:   rmux = {23'h0, fifo_valid, fifo_data};
            default:    rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_ph & hwrite;
            if (addr_ph) wr_addr_q <= haddr[7:0];
            if (addr_ph & ~hwrite) rdata_q <= rmux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q  <= '{bypass: 1'b0, decimation_divider: RST_DECIMATION_DIVIDER, adc_div: RST_ADC_DIV};
            fctl_q <= '{slicer_average_length: RST_SETTLE, expected_dev_exponent: RST_DEV_X,
                        expected_dev_mantissa: RST_DEV_M};
            clk_q  <= '{master_clock_div_second: RST_DIV2, master_clock_div_first: RST_DIV1,
                        ref_div: RST_REF_DIV};
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                OFF_CFG_A: begin
                    cfg_q.adc_div <= hwdata[POS_ADC_DIV +: 3];
                    cfg_q.decimation_divider <= hwdata[POS_DECIMATION_DIVIDER +: 5];
                    cfg_q.bypass  <= hwdata[POS_BYPASS];
                end
                OFF_FCTL: begin
                    fctl_q.expected_dev_mantissa <= hwdata[POS_DEV_M +: 4];
                    fctl_q.expected_dev_exponent <= hwdata[POS_DEV_X +: 2];
                    fctl_q.slicer_average_length <= hwdata[POS_SETTLE +: 2];
                end
                OFF_CLOCK: begin
                    clk_q.ref_div                 <= hwdata[POS_REF_DIV +: 3];
                    clk_q.master_clock_div_first  <= hwdata[POS_DIV1 +: 3];
                    clk_q.master_clock_div_second <= hwdata[POS_DIV2 +: 2];
                end
                default: ;
            endcase
        end
    end

    assign filter_bypass = cfg_q.bypass;

    // adc clock every 2*(div+1) cycles, IF phase every fourth adc pulse
    logic [3:0] adc_cnt_q;
    logic [1:0] if_ph_q;
    logic [3:0] adc_last;
    assign adc_last   = 4'(ADC_BASE_DIV) * {1'b0, cfg_q.adc_div} + 4'(ADC_BASE_DIV) - 4'h1;
    assign adc_clk_en = (adc_cnt_q == 4'h0);
    assign if_clk_en  = adc_clk_en & (if_ph_q == 2'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_cnt_q <= 4'h0;
            if_ph_q   <= 2'h0;
        end else begin
            adc_cnt_q <= (adc_cnt_q >= adc_last) ? 4'h0 : adc_cnt_q + 4'h1;
            if (adc_clk_en) if_ph_q <= if_ph_q + 2'h1;
        end
    end

    // channel filter: two-tap smoothing then keep one of decimation_divider+1 samples;
    // a wider boxcar would cost a divider for little gain at these widths
    logic              take;
    logic [4:0]        dec_cnt_q;
    logic signed [7:0] prev_q;
    logic signed [7:0] filt_q;
    logic              filt_valid_q;
    logic signed [8:0] pair_sum;
    logic              byte_valid_q;
    logic              fifo_in_ready;
    assign demod_ready = ~byte_valid_q | fifo_in_ready;
    assign take        = demod_valid & demod_ready;
    assign pair_sum    = 9'(demod_freq) + 9'(prev_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_cnt_q    <= 5'h00;
            prev_q       <= 8'sh00;
            filt_q       <= 8'sh00;
            filt_valid_q <= 1'b0;
        end else begin
            filt_valid_q <= 1'b0;
            if (take) begin
                prev_q <= demod_freq;
                if (dec_cnt_q >= cfg_q.decimation_divider) begin
                    dec_cnt_q    <= 5'h00;
                    filt_q       <= 8'(pair_sum >>> 1);
                    filt_valid_q <= 1'b1;
                end else begin
                    dec_cnt_q <= dec_cnt_q + 5'h01;
                end
            end
        end
    end

    // adaptive slicer
    logic [7:0]        dev;
    logic signed [8:0] diff;
    logic              up_q;
    logic signed [7:0] ref_q;
    logic signed [7:0] min_q;
    logic signed [7:0] max_q;
    logic [3:0]        trans_q;
    logic signed [8:0] mid;
    logic signed [8:0] step;
    logic              up_shift;
    logic              dn_shift;
    assign dev      = 8'({4'h0, fctl_q.expected_dev_mantissa} << fctl_q.expected_dev_exponent);
    assign diff     = 9'(filt_q) - 9'(ref_q);
    assign up_shift = diff > $signed({1'b0, dev});
    assign dn_shift = diff < -$signed({1'b0, dev});
    assign mid      = (9'(min_q) + 9'(max_q)) >>> 1;
    assign step     = (mid - 9'(level_q)) >>> (fctl_q.slicer_average_length - 2'h1);
    assign locked   = (trans_q >= 4'(MIN_TRANS));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q    <= 1'b0;
            ref_q   <= 8'sh00;
            min_q   <= 8'sh00;
            max_q   <= 8'sh00;
            trans_q <= 4'h0;
        end else if (filt_valid_q) begin
            if (up_shift | dn_shift) begin
                ref_q   <= filt_q;
                up_q    <= up_shift;
                trans_q <= (trans_q == 4'hF) ? trans_q : trans_q + 4'h1;
                if (up_shift) max_q <= filt_q;
                else min_q <= filt_q;
            end else if (up_q && filt_q > max_q) begin
                max_q <= filt_q;
                ref_q <= filt_q;
            end else if (!up_q && filt_q < min_q) begin
                min_q <= filt_q;
                ref_q <= filt_q;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 8'sh00;
        end else if (fctl_q.slicer_average_length == 2'h0) begin
            level_q <= 8'sh00;
        end else if (filt_valid_q && locked) begin
            level_q <= 8'(9'(level_q) + step);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sliced_bit <= 1'b0;
        end else if (filt_valid_q) begin
            sliced_bit <= (filt_q > level_q);
        end
    end

    // oversample tick: bit period is 4*(ref+1)*2*div1*div2 hclk cycles
    logic [7:0]  div1x2;
    logic [3:0]  div2;
    logic [13:0] os_last;
    logic [13:0] os_cnt_q;
    logic        os_tick;
    always_comb begin
        div1x2 = 8'd5;
        unique case (clk_q.master_clock_div_first)
            3'h0: div1x2 = 8'd5;
            3'h1: div1x2 = 8'd6;
            3'h2: div1x2 = 8'd8;
            3'h3: div1x2 = 8'd15;
            3'h4: div1x2 = 8'd25;
            3'h5: div1x2 = 8'd80;
            3'h6: div1x2 = 8'd96;
            3'h7: div1x2 = 8'd128;
        endcase
    end
    assign div2    = 4'h1 << clk_q.master_clock_div_second;
    assign os_last = 14'(({11'h0, clk_q.ref_div} + 14'h1) * 14'(div1x2) * 14'(div2)) - 14'h1;
    assign os_tick = (os_cnt_q == 14'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            os_cnt_q <= 14'h0;
        end else begin
            os_cnt_q <= (os_cnt_q >= os_last) ? 14'h0 : os_cnt_q + 14'h1;
        end
    end

    // bit synchronizer: four votes per bit, realigned on a slicer edge seen at any tick but the deciding one
    logic [1:0] phase_q;
    logic [2:0] votes_q;
    logic       last_q;
    logic [2:0] total;
    logic       decide;
    logic       edge_seen;
    assign total     = votes_q + {2'h0, sliced_bit};
    assign edge_seen = (sliced_bit != last_q);
    assign decide    = (total > 3'h2) | ((total == 3'h2) & sliced_bit);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q      <= 2'h0;
            votes_q      <= 3'h0;
            last_q       <= 1'b0;
            rx_bit       <= 1'b0;
            rx_bit_valid <= 1'b0;
        end else begin
            rx_bit_valid <= 1'b0;
            if (os_tick) begin
                last_q <= sliced_bit;
                if (edge_seen && phase_q != 2'(OVERSAMPLE - 1)) begin
                    phase_q <= 2'h1;
                    votes_q <= {2'h0, sliced_bit};
                end else if (phase_q == 2'(OVERSAMPLE - 1)) begin
                    phase_q      <= 2'h0;
                    votes_q      <= 3'h0;
                    rx_bit       <= decide;
                    rx_bit_valid <= 1'b1;
                end else begin
                    phase_q <= phase_q + 2'h1;
                    votes_q <= total;
                end
            end
        end
    end

    // byte packing; a full fifo holds the byte and stalls the sample stream
    logic [7:0] shift_q;
    logic [2:0] nbit_q;
    logic [7:0] byte_q;
    assign overrun_set = rx_bit_valid & (nbit_q == 3'h7) & byte_valid_q & ~fifo_in_ready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_q      <= 8'h00;
            nbit_q       <= 3'h0;
            byte_q       <= 8'h00;
            byte_valid_q <= 1'b0;
        end else begin
            if (byte_valid_q & fifo_in_ready) byte_valid_q <= 1'b0;
            if (rx_bit_valid) begin
                shift_q <= {rx_bit, shift_q[7:1]};
                nbit_q  <= nbit_q + 3'h1;
                if (nbit_q == 3'h7 && !overrun_set) begin
                    byte_q       <= {rx_bit, shift_q[7:1]};
                    byte_valid_q <= 1'b1;
                end
            end
        end
    end

    // overrun is sticky; a new overrun wins over a clearing write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overrun_q <= 1'b0;
        end else if (overrun_set) begin
            overrun_q <= 1'b1;
        end else if (wr_pend_q && wr_addr_q == OFF_STATUS && hwdata[POS_OVERRUN]) begin
            overrun_q <= 1'b0;
        end
    end

    fkr_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (byte_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (byte_q),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data),
        .count     (fifo_count)
    );

    // assertion helpers
    logic [4:0] adc_gap_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) adc_gap_q <= 5'h00;
        else adc_gap_q <= adc_clk_en ? 5'h01 : adc_gap_q + 5'h01;
    end

    // adc pulses seen since the last IF pulse, counted apart from if_ph_q
    logic [2:0] if_gap_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) if_gap_q <= 3'h0;
        else if (if_clk_en) if_gap_q <= 3'h1;
        else if (adc_clk_en) if_gap_q <= if_gap_q + 3'h1;
    end

    sequence s_bit_out;
        rx_bit_valid ##1 !rx_bit_valid [*8];
    endsequence

    property p_adc_period;
        @(posedge hclk) disable iff (!hresetn)
        adc_clk_en && $stable(cfg_q.adc_div) && $past(adc_cnt_q) == adc_last
            |-> adc_gap_q == 5'(adc_last) + 5'h1;
    endproperty
    a_adc_period: assert property (p_adc_period) else $error("adc pulse spacing wrong");

    property p_if_quarter;
        @(posedge hclk) disable iff (!hresetn)
        if_clk_en && if_gap_q != 3'h0 |-> adc_clk_en && if_gap_q == 3'(IF_PER_ADC);
    endproperty
    a_if_quarter: assert property (p_if_quarter) else $error("IF pulse not every fourth adc pulse");

    property p_dec_keep;
        @(posedge hclk) disable iff (!hresetn)
        filt_valid_q |-> $past(take) && $past(dec_cnt_q) >= $past(cfg_q.decimation_divider);
    endproperty
    a_dec_keep: assert property (p_dec_keep) else $error("decimated sample without cause");

    property p_trans;
        @(posedge hclk) disable iff (!hresetn)
        filt_valid_q && (up_shift || dn_shift) && trans_q != 4'hF |=> trans_q == $past(trans_q) + 4'h1;
    endproperty
    a_trans: assert property (p_trans) else $error("transition not recorded");

    property p_lock_first;
        @(posedge hclk) disable iff (!hresetn)
        $changed(level_q) && fctl_q.slicer_average_length != 2'h0 |-> $past(trans_q) >= 4'(MIN_TRANS);
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("level moved before lock");

    property p_symmetric;
        @(posedge hclk) disable iff (!hresetn)
        fctl_q.slicer_average_length == 2'h0 |=> level_q == 8'sh00;
    endproperty
    a_symmetric: assert property (p_symmetric) else $error("level not centred");

    property p_slice;
        @(posedge hclk) disable iff (!hresetn)
        filt_valid_q |=> sliced_bit == ($past(filt_q) > $past(level_q));
    endproperty
    a_slice: assert property (p_slice) else $error("slicer polarity wrong");

    property p_bit_spacing;
        @(posedge hclk) disable iff (!hresetn)
        rx_bit_valid |-> s_bit_out;
    endproperty
    a_bit_spacing: assert property (p_bit_spacing) else $error("bits decided too close");
endmodule : fkr_rx_core
`default_nettype wire

// >>> test/fkr_tx_model.sv
// Purpose: remote fsk transmitter seen as a demodulated sample source
// Assumes: one sample per hclk while the core is ready
// Notes: alternating preamble, offset carrier, line toggles when idle
`timescale 1ns/1ps
`default_nettype none
module fkr_tx_model (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // control and stream
    input  wire logic         run,
    input  wire logic         demod_ready,
    output logic              demod_valid,
    output logic signed [7:0] demod_freq,
    // bit timing seen by the bench
    output logic              tx_bit,
    output logic [4:0]        phase
);
    localparam logic signed [7:0] OFFS = 8'sh0A;
    localparam logic signed [7:0] DEV  = 8'sh28;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            demod_valid <= 1'b0;
            demod_freq  <= 8'sh00;
            tx_bit      <= 1'b0;
            phase       <= 5'h00;
        end else if (!run) begin
            demod_valid <= 1'b0;
            demod_freq  <= ~demod_freq; // released line must not look stable
        end else if (!demod_valid || demod_ready) begin
            demod_valid <= 1'b1;
            demod_freq  <= tx_bit ? OFFS + DEV : OFFS - DEV;
            phase       <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
            if (phase == 5'h13) begin
                tx_bit <= ~tx_bit; // 0101 preamble, 20 samples a bit
            end
        end
    end
endmodule : fkr_tx_model
`default_nettype wire

// >>> test/test_fsk_rx_if_filter_and_slicer.sv
// Purpose: self-checking bench of the fsk receive core
// Assumes: ahb-lite slave, clock register at reset value until the fifo scenario
// Notes: slicer level expected at the transmitter offset
`timescale 1ns/1ps
`default_nettype none
module test_fsk_rx_if_filter_and_slicer;
    import fkr_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, run, demod_valid, demod_ready;
    logic adc_clk_en, if_clk_en, filter_bypass, sliced_bit, rx_bit, rx_bit_valid, tx_bit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] phase;
    logic signed [7:0] demod_freq;
    int err_count, tests_run, a, f;
    assign hready = hreadyout;
    fkr_rx_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .demod_freq(demod_freq), .demod_valid(demod_valid),
        .demod_ready(demod_ready), .adc_clk_en(adc_clk_en), .if_clk_en(if_clk_en),
        .filter_bypass(filter_bypass), .sliced_bit(sliced_bit), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    fkr_tx_model tx (.hclk(hclk), .hresetn(hresetn), .run(run), .demod_ready(demod_ready),
        .demod_valid(demod_valid), .demod_freq(demod_freq), .tx_bit(tx_bit), .phase(phase));
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ad};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic pulses(input int n);
        a = 0;
        f = 0;
        repeat (n) begin
            @(posedge hclk);
            a += int'(adc_clk_en === 1'b1);
            f += int'(if_clk_en === 1'b1);
        end
    endtask : pulses
    task automatic t_clocks();
        bus(0, OFF_CFG_A, 0);  chk("cfg rst", rd, 32'h00000003);
        bus(0, OFF_FCTL, 0);   chk("fctl rst", rd, 32'h00000214);
        bus(0, OFF_CLOCK, 0);  chk("clock rst", rd, 32'h00000000);
        bus(0, 8'h1C, 0);      chk("unmapped", rd, 32'h00000000);
        chk("okay", hresp, 0);
        bus(1, OFF_CFG_A, 32'h00001181);
        bus(0, OFF_CFG_A, 0);  chk("cfg", rd, 32'h00001181);
        chk("bypass", filter_bypass, 1);
        pulses(80);
        chk("adc div1", a, 20);
        chk("if div1", f, 5);
        bus(1, OFF_CFG_A, 32'h00000000);
        pulses(80);
        chk("adc div0", a, 40);
        chk("if div0", f, 10);
    endtask : t_clocks
    task automatic t_slicer();
        bus(1, OFF_FCTL, 32'h00000014);
        run <= 1'b1;
        repeat (400) @(posedge hclk);
        bus(0, OFF_OFFSET, 0); chk("level off", rd, 0);
        bus(1, OFF_FCTL, 32'h00000114);
        repeat (400) @(posedge hclk);
        bus(0, OFF_STATUS, 0); chk("locked", rd[9], 1);
        // read mid-bit: min or max holds the halfway sample for a sample right after each transition
        do @(posedge hclk); while (phase !== 5'h08);
        bus(0, OFF_OFFSET, 0); chk("level", rd, 32'h0000000A);
        repeat (4) begin
            do @(posedge hclk); while (phase !== 5'h0A);
            chk("sliced", sliced_bit, tx_bit);
        end
        a = 0;
        repeat (200) begin
            @(posedge hclk);
            a += int'(rx_bit_valid === 1'b1);
        end
        chk("bit rate", a, 10);
    endtask : t_slicer
    task automatic t_fifo();
        repeat (3000) @(posedge hclk);
        run <= 1'b0; // far side stalled behind a full buffer
        bus(0, OFF_STATUS, 0); chk("full", rd[4:0], 5'h10);
        chk("overrun", rd[8], 1);
        // slowest bit clock, so no new byte lands while draining
        bus(1, OFF_CLOCK, 32'h00000377);
        a = 0;
        do begin
            bus(0, OFF_DATA, 0);
            a += int'(rd[8] === 1'b1);
        end while (rd[8] === 1'b1 && a < 20);
        chk("drained", a >= 16 && a <= 17, 1);
        bus(1, OFF_STATUS, 32'h00000100);
        bus(0, OFF_STATUS, 0); chk("empty", rd[4:0], 5'h00);
        chk("overrun clr", rd[8], 0);
        // bit is 8*(1+1)*3*2 = 96 cycles with a quiet line
        bus(1, OFF_CLOCK, 32'h00000111);
        repeat (2) do @(posedge hclk); while (rx_bit_valid !== 1'b1);
        a = 0;
        repeat (960) begin
            @(posedge hclk);
            a += int'(rx_bit_valid === 1'b1);
        end
        chk("slow rate", a, 10);
    endtask : t_fifo
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        {hresetn, hsel, hwrite, run, htrans, hsize, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_clocks();
        t_slicer();
        t_fifo();
        wrap_up();
    end
endmodule : test_fsk_rx_if_filter_and_slicer
`default_nettype wire
